/* File: verilog/gpf_defines.svh */
// Constants for the pin function select block: offsets, fields, timing
// -----------------------------------------------------------------------
// Summary of operation
// [R1] After reset pins 3 to 7 are inputs until configured otherwise.
// [R2] Pins 3 to 7 select plain input, plain output, LED flash or ID strap.
// [R3] Outputs on pins 3 to 7 choose push-pull, open-drain or open-collector.
// [R4] Pins 8 to 10 may raise a management event or bus alert.
// [R5] Pins 8 to 10 offer only plain input and plain output.
// [R6] Pin 11 resets as input and as input may raise interrupts.
// [R7] Pin 12 resets as input; interrupt input, output, or select bit 0.
// [R8] Select code 00 none, 01 bus one, 10 bus two, 11 bus three.
// [R9] Select code bit 1 is driven on pin 13 in select mode.
// [R10] An input pin keeps its driver off, presenting high impedance.
// -----------------------------------------------------------------------
`ifndef GPF_DEFINES_SVH
`define GPF_DEFINES_SVH

// Pin ranges
`define GPF_PIN_LO       3
`define GPF_PIN_HI       13
`define GPF_FLASH_HI     7
`define GPF_IRQ_LO       8
`define GPF_SEL0_PIN     12
`define GPF_NFLASH       5
`define GPF_NIRQ         6

// Register byte offsets
`define GPF_OFS_FUNC     8'h00
`define GPF_OFS_DRIVE    8'h04
`define GPF_OFS_DIR      8'h08
`define GPF_OFS_OUT      8'h0c
`define GPF_OFS_IN       8'h10
`define GPF_OFS_INTCFG   8'h14
`define GPF_OFS_STATUS   8'h18
`define GPF_OFS_MASK     8'h1c
`define GPF_OFS_BUSSEL   8'h20
`define GPF_OFS_LED      8'h24
`define GPF_OFS_ID       8'h28

// Field positions
`define GPF_POL_LSB      8
`define GPF_ROUTE_LSB    16
`define GPF_SELEN_BIT    8

// Timing
`define GPF_CLK_PERIOD_NS    5
`define GPF_FLASH_PERIOD_NS  500000000
`define GPF_ID_SETTLE        2'h3

`endif

/* File: verilog/gpf_pkg.sv */
// Types shared by the pin function select block
`default_nettype none
package gpf_pkg;

   // Function of pins 3 to 7
   typedef enum logic [1:0] {
      GPF_FN_INPUT  = 2'h0,
      GPF_FN_OUTPUT = 2'h1,
      GPF_FN_FLASH  = 2'h2,
      GPF_FN_STRAP  = 2'h3
   } gpf_func_type;

   // Output driver style
   typedef enum logic [1:0] {
      GPF_DRV_PUSH  = 2'h0,
      GPF_DRV_DRAIN = 2'h1,
      GPF_DRV_COLL  = 2'h2
   } gpf_drive_type;

   // Per-pin driver request
   typedef struct packed {
      logic          oe;
      logic          data;
      gpf_drive_type drive;
   } gpf_pin_cfg_type;

endpackage
`default_nettype wire

/* File: verilog/gpf_pin_cell.sv */
// One pad driver: turns a driver request into registered out and enable
`default_nettype none
module gpf_pin_cell (
   input  wire logic                     mclk,
   input  wire logic                     rst,
   input  wire gpf_pkg::gpf_pin_cfg_type cfg,
   output logic                          pad_out,
   output logic                          pad_oe_n
);

   // Driver style decode; enable low while the pad is driven
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pad_out  <= 1'h0;
         pad_oe_n <= 1'h1;
      end else if (!cfg.oe) begin
         pad_out  <= 1'h0;
         pad_oe_n <= 1'h1;                          // see [R10]
      end else begin
         unique case (cfg.drive)                    // see [R3]
            gpf_pkg::GPF_DRV_DRAIN: begin
               pad_out  <= 1'h0;                    // Pull low on 0 only
               pad_oe_n <= cfg.data;
            end
            gpf_pkg::GPF_DRV_COLL: begin
               pad_out  <= 1'h0;                    // Sink on 1, inverting
               pad_oe_n <= ~cfg.data;
            end
            default: begin
               pad_out  <= cfg.data;
               pad_oe_n <= 1'h0;
            end
         endcase
      end
   end

   a_input_hiz: assert property (@(posedge mclk) disable iff (rst) // see [R10]
      !cfg.oe |=> pad_oe_n)
      else $error("input pad is being driven");

   a_push_drive: assert property (@(posedge mclk) disable iff (rst) // see [R3]
      (cfg.oe && cfg.drive == gpf_pkg::GPF_DRV_PUSH)
      |=> (!pad_oe_n && pad_out == $past(cfg.data)))
      else $error("push-pull pad level wrong");

   a_drain_drive: assert property (@(posedge mclk) disable iff (rst) // see [R3]
      (cfg.oe && cfg.drive == gpf_pkg::GPF_DRV_DRAIN)
      |=> (!pad_out && pad_oe_n == $past(cfg.data)))
      else $error("open-drain pad level wrong");

endmodule // gpf_pin_cell
`default_nettype wire

/* File: verilog/gpf_top.sv */
// Pin function select for pins 3 to 13 with APB registers and interrupts
//
// The implementer's own choices: the register offsets and the APB slave port.
`include "gpf_defines.svh"
`default_nettype none
module gpf_top #(
   parameter int unsigned FLASH_CYCLES =
      `GPF_FLASH_PERIOD_NS / `GPF_CLK_PERIOD_NS
) (
   input  wire logic                            mclk,
   input  wire logic                            rst,
   input  wire logic [7:0]                      paddr,
   input  wire logic                            psel,
   input  wire logic                            penable,
   input  wire logic                            pwrite,
   input  wire logic [31:0]                     pwdata,
   output logic      [31:0]                     prdata,
   output logic                                 pready,
   output logic                                 pslverr,
   input  wire logic [`GPF_PIN_HI:`GPF_PIN_LO]  gpio_in,
   output logic      [`GPF_PIN_HI:`GPF_PIN_LO]  gpio_out,
   output logic      [`GPF_PIN_HI:`GPF_PIN_LO]  gpio_oe_n,
   output logic                                 system_mgmt_event,
   output logic                                 bus_alert_n,
   output logic                                 irq,
   output logic      [2:0]                      sec_bus_en
);

   localparam int NPIN = `GPF_PIN_HI - `GPF_PIN_LO + 1;

   initial begin
      if (FLASH_CYCLES < 10)
         $error("FLASH_CYCLES must be at least 10");
   end

   // -----------------------------------------------------------------
   // Storage
   // -----------------------------------------------------------------
   logic [NPIN-1:0]                             gpio_meta_reg;
   logic [NPIN-1:0]                             gpio_sync_reg;
   logic [NPIN-1:0]                             gpio_prev_reg;
   gpf_pkg::gpf_func_type  [`GPF_NFLASH-1:0]    func_reg;
   gpf_pkg::gpf_drive_type [`GPF_NFLASH-1:0]    drive_reg;
   logic [`GPF_NIRQ-1:0]                        dir_reg;
   logic [NPIN-1:0]                             out_reg;
   logic [`GPF_NIRQ-1:0]                        int_en_reg;
   logic [`GPF_NIRQ-1:0]                        int_pol_reg;
   logic [`GPF_NIRQ-1:0]                        int_route_reg;
   logic [`GPF_NIRQ-1:0]                        status_reg;
   logic [`GPF_NIRQ-1:0]                        status_next;
   logic [`GPF_NIRQ-1:0]                        mask_reg;
   logic [1:0]                                  code_reg;
   logic                                        sel_en_reg;
   logic                                        duty_reg;
   logic [`GPF_NFLASH-1:0]                      id_reg;
   logic [1:0]                                  id_cnt_reg;
   logic [31:0]                                 flash_cnt_reg;
   logic                                        flash_on_reg;
   logic [31:0]                                 rdata_next;
   logic                                        hit_next;
   logic [NPIN-1:0]                             pin_oe;
   logic [`GPF_NIRQ-1:0]                        event_hit;
   gpf_pkg::gpf_pin_cfg_type [NPIN-1:0]         pin_cfg;

   wire logic setup  = psel & ~penable;
   wire logic access = psel & penable & pready;
   wire logic wr     = access & pwrite;
   wire logic rd_st  = access & ~pwrite & (paddr == `GPF_OFS_STATUS);

   // -----------------------------------------------------------------
   // Pin input synchroniser
   // -----------------------------------------------------------------
   // Two stages, then one more for edge detection
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         gpio_meta_reg <= '0;
         gpio_sync_reg <= '0;
         gpio_prev_reg <= '0;
      end else begin
         gpio_meta_reg <= gpio_in;
         gpio_sync_reg <= gpio_meta_reg;
         gpio_prev_reg <= gpio_sync_reg;
      end
   end

   // -----------------------------------------------------------------
   // APB slave
   // -----------------------------------------------------------------
   // Read mux, sampled in the setup cycle
   always_comb begin
      rdata_next = 32'h0000_0000;
      hit_next   = 1'h1;
      unique case (paddr)
         `GPF_OFS_FUNC:   rdata_next[9:0] = func_reg;
         `GPF_OFS_DRIVE:  rdata_next[9:0] = drive_reg;
         `GPF_OFS_DIR:    rdata_next[`GPF_NIRQ-1:0] = dir_reg;
         `GPF_OFS_OUT:    rdata_next[NPIN-1:0] = out_reg;
         `GPF_OFS_IN:     rdata_next[NPIN-1:0] = gpio_sync_reg;
         `GPF_OFS_INTCFG: begin
            rdata_next[`GPF_NIRQ-1:0] = int_en_reg;
            rdata_next[`GPF_POL_LSB +: `GPF_NIRQ] = int_pol_reg;
            rdata_next[`GPF_ROUTE_LSB +: `GPF_NIRQ] = int_route_reg;
         end
         `GPF_OFS_STATUS: rdata_next[`GPF_NIRQ-1:0] = status_reg;
         `GPF_OFS_MASK:   rdata_next[`GPF_NIRQ-1:0] = mask_reg;
         `GPF_OFS_BUSSEL: begin
            rdata_next[1:0] = code_reg;
            rdata_next[`GPF_SELEN_BIT] = sel_en_reg;
         end
         `GPF_OFS_LED:    rdata_next[0] = duty_reg;
         `GPF_OFS_ID:     rdata_next[`GPF_NFLASH-1:0] = id_reg;
         default:         hit_next = 1'h0;
      endcase
   end

   // Answer one cycle after setup: first access cycle has pready high
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pready  <= 1'h0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'h0;
      end else begin
         pready  <= setup;
         prdata  <= setup ? rdata_next : prdata;
         pslverr <= setup & ~hit_next;
      end
   end

   // Configuration writes take effect at the access edge
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         func_reg      <= type(func_reg)'(
            {`GPF_NFLASH{gpf_pkg::GPF_FN_INPUT}});              // see [R1]
         drive_reg     <= type(drive_reg)'(
            {`GPF_NFLASH{gpf_pkg::GPF_DRV_PUSH}});
         dir_reg       <= '0;                                  // see [R6]
         out_reg       <= '0;
         int_en_reg    <= '0;
         int_pol_reg   <= '0;
         int_route_reg <= '0;
         mask_reg      <= '0;
         code_reg      <= 2'h0;
         sel_en_reg    <= 1'h0;                                // see [R7]
         duty_reg      <= 1'h0;
      end else if (wr) begin
         unique case (paddr)
            `GPF_OFS_FUNC:                                     // see [R2]
               func_reg  <= type(func_reg)'(pwdata[9:0]);
            `GPF_OFS_DRIVE:                                    // see [R3]
               drive_reg <= type(drive_reg)'(pwdata[9:0]);
            `GPF_OFS_DIR:   dir_reg   <= pwdata[`GPF_NIRQ-1:0];
            `GPF_OFS_OUT:   out_reg   <= pwdata[NPIN-1:0];
            `GPF_OFS_INTCFG: begin
               int_en_reg    <= pwdata[`GPF_NIRQ-1:0];
               int_pol_reg   <= pwdata[`GPF_POL_LSB +: `GPF_NIRQ];
               int_route_reg <= pwdata[`GPF_ROUTE_LSB +: `GPF_NIRQ];
            end
            `GPF_OFS_MASK:  mask_reg  <= pwdata[`GPF_NIRQ-1:0];
            `GPF_OFS_BUSSEL: begin
               code_reg   <= pwdata[1:0];
               sel_en_reg <= pwdata[`GPF_SELEN_BIT];
            end
            `GPF_OFS_LED:   duty_reg  <= pwdata[0];
            default: ;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Strap capture and flash timing
   // -----------------------------------------------------------------
   // Strap levels latched once the synchroniser has settled
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         id_cnt_reg <= 2'h0;
         id_reg     <= '0;
      end else if (id_cnt_reg != `GPF_ID_SETTLE) begin
         id_cnt_reg <= id_cnt_reg + 2'h1;
         if (id_cnt_reg + 2'h1 == `GPF_ID_SETTLE)
            id_reg <= gpio_sync_reg[`GPF_NFLASH-1:0];          // see [R2]
      end
   end

   // Free-running flash period with 10 or 50 percent on time
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flash_cnt_reg <= 32'h0000_0000;
         flash_on_reg  <= 1'h0;
      end else begin
         if (flash_cnt_reg == FLASH_CYCLES - 1)
            flash_cnt_reg <= 32'h0000_0000;
         else
            flash_cnt_reg <= flash_cnt_reg + 32'h0000_0001;
         flash_on_reg <= flash_cnt_reg <
            (duty_reg ? 32'(FLASH_CYCLES / 2) : 32'(FLASH_CYCLES / 10));
      end
   end

   // -----------------------------------------------------------------
   // Pin drivers
   // -----------------------------------------------------------------
   genvar p;
   generate
      for (p = 0; p < NPIN; p++) begin : g_pin
         if (p + `GPF_PIN_LO <= `GPF_FLASH_HI) begin : g_full
            // Four functions and three driver styles
            always_comb begin
               pin_cfg[p].oe = (func_reg[p] == gpf_pkg::GPF_FN_OUTPUT) ||
                               (func_reg[p] == gpf_pkg::GPF_FN_FLASH);
               pin_cfg[p].data = (func_reg[p] == gpf_pkg::GPF_FN_FLASH) ?
                                 flash_on_reg : out_reg[p];   // see [R2]
               pin_cfg[p].drive = drive_reg[p];
            end
         end else if (p + `GPF_PIN_LO < `GPF_SEL0_PIN) begin : g_plain
            // Plain input or output only
            always_comb begin
               pin_cfg[p].oe    = dir_reg[p - `GPF_NFLASH];   // see [R5]
               pin_cfg[p].data  = out_reg[p];
               pin_cfg[p].drive = gpf_pkg::GPF_DRV_PUSH;
            end
         end else begin : g_sel
            // Select mode drives one bit of the bus code
            always_comb begin
               pin_cfg[p].oe    = sel_en_reg | dir_reg[p - `GPF_NFLASH];
               pin_cfg[p].data  = sel_en_reg ?                // see [R7]
                  code_reg[p + `GPF_PIN_LO - `GPF_SEL0_PIN] :  // see [R9]
                  out_reg[p];
               pin_cfg[p].drive = gpf_pkg::GPF_DRV_PUSH;
            end
         end
         assign pin_oe[p] = pin_cfg[p].oe;
         gpf_pin_cell u_cell (
            .mclk     (mclk),
            .rst      (rst),
            .cfg      (pin_cfg[p]),
            .pad_out  (gpio_out[p + `GPF_PIN_LO]),
            .pad_oe_n (gpio_oe_n[p + `GPF_PIN_LO])
         );
      end
   endgenerate

   // -----------------------------------------------------------------
   // Pin events and interrupts
   // -----------------------------------------------------------------
   // Edge of the chosen polarity on an enabled input pin
   genvar k;
   generate
      for (k = 0; k < `GPF_NIRQ; k++) begin : g_evt
         localparam int P = k + `GPF_IRQ_LO - `GPF_PIN_LO;
         assign event_hit[k] = int_en_reg[k] & ~pin_oe[P] &  // see [R6]
            (int_pol_reg[k] ? (gpio_sync_reg[P] & ~gpio_prev_reg[P])
                            : (~gpio_sync_reg[P] & gpio_prev_reg[P]));
      end
   endgenerate

   // Sticky status; read clears what was read, a new event wins
   assign status_next = (status_reg & ~(rd_st ? prdata[`GPF_NIRQ-1:0]
                         : {`GPF_NIRQ{1'h0}})) | event_hit;  // see [R4]

   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         status_reg <= '0;
      else
         status_reg <= status_next;
   end

   // Unmasked status routed to event, alert and irq outputs
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq               <= 1'h0;
         system_mgmt_event <= 1'h0;
         bus_alert_n       <= 1'h1;
      end else begin
         irq               <= |(status_reg & mask_reg);
         system_mgmt_event <= |(status_reg & mask_reg & ~int_route_reg);
         bus_alert_n       <= ~|(status_reg & mask_reg & int_route_reg);
      end
   end

   // Secondary bus one-hot select
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         sec_bus_en <= 3'h0;
      else if (!sel_en_reg)
         sec_bus_en <= 3'h0;
      else
         unique case (code_reg)                                // see [R8]
            2'h1:    sec_bus_en <= 3'h1;
            2'h2:    sec_bus_en <= 3'h2;
            2'h3:    sec_bus_en <= 3'h4;
            default: sec_bus_en <= 3'h0;
         endcase
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   a_reset_inputs: assert property (@(posedge mclk)                // see [R1]
      $fell(rst) |-> gpio_oe_n[`GPF_FLASH_HI:`GPF_PIN_LO] == 5'h1f)
      else $error("pins 3 to 7 not inputs after reset");

   a_flash_drive: assert property (@(posedge mclk) disable iff (rst) // see [R2]
      (func_reg[0] == gpf_pkg::GPF_FN_FLASH &&
       drive_reg[0] == gpf_pkg::GPF_DRV_PUSH) ##1
      (func_reg[0] == gpf_pkg::GPF_FN_FLASH &&
       drive_reg[0] == gpf_pkg::GPF_DRV_PUSH)
      |-> gpio_out[`GPF_PIN_LO] == $past(flash_on_reg))
      else $error("flash pin does not follow flash timer");

   a_event_sets: assert property (@(posedge mclk) disable iff (rst) // see [R4]
      event_hit[0] |=> status_reg[0] ##2 (irq == mask_reg[0] || !status_reg[0]))
      else $error("pin event not latched");

   a_plain_only: assert property (@(posedge mclk) disable iff (rst) // see [R5]
      dir_reg[0] |=> !gpio_oe_n[`GPF_IRQ_LO] &&
         gpio_out[`GPF_IRQ_LO] == $past(out_reg[`GPF_IRQ_LO - `GPF_PIN_LO]))
      else $error("pin 8 output not plain");

   a_output_quiet: assert property (@(posedge mclk) disable iff (rst) // see [R6]
      dir_reg[3] |-> !event_hit[3])
      else $error("pin 11 raised event while output");

   sequence s_sel_on;
      sel_en_reg ##1 sel_en_reg;
   endsequence

   a_sel_bit0: assert property (@(posedge mclk) disable iff (rst) // see [R7]
      s_sel_on |-> !gpio_oe_n[`GPF_SEL0_PIN] &&
         gpio_out[`GPF_SEL0_PIN] == $past(code_reg[0]))
      else $error("select bit 0 wrong on pin 12");

   a_sel_bit1: assert property (@(posedge mclk) disable iff (rst) // see [R9]
      s_sel_on |-> !gpio_oe_n[`GPF_PIN_HI] &&
         gpio_out[`GPF_PIN_HI] == $past(code_reg[1]))
      else $error("select bit 1 wrong on pin 13");

   a_bus_decode: assert property (@(posedge mclk) disable iff (rst) // see [R8]
      s_sel_on |-> sec_bus_en == (($past(code_reg) == 2'h0) ? 3'h0 :
         3'(3'h1 << ($past(code_reg) - 2'h1))))
      else $error("secondary bus decode wrong");

   a_input_hiz: assert property (@(posedge mclk) disable iff (rst) // see [R10]
      (!dir_reg[1] ##1 !dir_reg[1]) |-> gpio_oe_n[`GPF_IRQ_LO + 1])
      else $error("pin 9 driven while input");

endmodule // gpf_top
`default_nettype wire

/* File: bench/gpf_board.sv */
// Board model: external levels and the pad levels seen by the pin inputs
`default_nettype none
module gpf_board (
   input  wire logic [13:3] pad_out,
   input  wire logic [13:3] pad_oe_n,
   input  wire logic [13:3] ext_lvl,
   output logic      [13:3] pad_in
);
   timeunit 1ns;
   timeprecision 100ps;
   // Driven pads show the driver, released pads the board level
   always_comb begin
      for (int i = 3; i <= 13; i++) begin
         pad_in[i] = pad_oe_n[i] ? ext_lvl[i] : pad_out[i];
      end
   end
endmodule // gpf_board
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the pin function select block
`include "gpf_defines.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        mclk, rst, psel, penable, pwrite, pready, pslverr, irq;
   logic        system_mgmt_event, bus_alert_n, e_oe, e_out;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, lfsr;
   logic [13:3] gpio_in, gpio_out, gpio_oe_n, ext_lvl;
   logic [2:0]  sec_bus_en;
   logic [32:0] exp_q[$];
   int          error_cnt, total_checks;

   gpf_top #(.FLASH_CYCLES(20)) gpf_top_inst (.mclk(mclk), .rst(rst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
      .system_mgmt_event(system_mgmt_event), .bus_alert_n(bus_alert_n),
      .irq(irq), .sec_bus_en(sec_bus_en));
   gpf_board gpf_board_inst (.pad_out(gpio_out), .pad_oe_n(gpio_oe_n),
      .ext_lvl(ext_lvl), .pad_in(gpio_in));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string nm, input logic [32:0] seen,
                        input logic [32:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // APB transfer, entered just after a rising edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         end_of_test();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   // Read with the expected word and error flag noted for the monitor
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic e);
      exp_q.push_back({e, d});
      apb(1'b0, a, 32'h0);
   endtask

   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 20) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 20) begin
         error_cnt++;
         end_of_test();
      end
   endtask

   // Read monitor: compares each completed read against the oldest note
   always @(posedge mclk) begin
      if (psel && penable && pready && !pwrite) begin
         if (exp_q.size() == 0) check("queue", 33'h0, 33'h1);
         else check("prdata", {pslverr, prdata}, exp_q.pop_front());
      end
   end

   // Clock and watchdog
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      #400000;
      error_cnt++;
      end_of_test();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      lfsr = lfsr_next(32'hab5ce1af);
      ext_lvl = {6'h00, lfsr[4:0]};
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1;
      check("oe_n rst", gpio_oe_n, 11'h7ff);
      check("bus en", sec_bus_en, 3'h0);
      repeat (5) @(posedge mclk);
      rd(`GPF_OFS_ID, {27'h0, ext_lvl[7:3]}, 1'b0);
      rd(`GPF_OFS_FUNC, 32'h0, 1'b0);
      rd(8'h40, 32'h0, 1'b1);
      // Flash duty select reads back as written
      apb(1'b1, `GPF_OFS_LED, 32'h1);
      rd(`GPF_OFS_LED, 32'h1, 1'b0);
      apb(1'b1, `GPF_OFS_LED, 32'h0);
      rd(`GPF_OFS_LED, 32'h0, 1'b0);
      // Every function of pin 3, push-pull drive
      for (int f = 0; f < 4; f++) begin
         apb(1'b1, `GPF_OFS_FUNC, f);
         #1;
         check("oe3 fn", gpio_oe_n[3], f == 0 || f == 3);
         @(posedge mclk);
      end
      // Drive styles with both data levels, random upper data bits
      apb(1'b1, `GPF_OFS_FUNC, 32'h1);
      for (int d = 0; d < 3; d++) begin
         for (int v = 0; v < 2; v++) begin
            lfsr = lfsr_next(lfsr);
            apb(1'b1, `GPF_OFS_DRIVE, d);
            apb(1'b1, `GPF_OFS_OUT, {lfsr[31:1], v[0]} & 32'h1f);
            #1;
            e_oe = (d == 0) ? 1'b0 : (d == 1) ? v[0] : !v[0];
            e_out = (d == 2) ? 1'b0 : v[0];
            check("oe3", gpio_oe_n[3], e_oe);
            if (!e_oe) check("out3", gpio_out[3], e_out);
            @(posedge mclk);
         end
      end
      // Plain output on pin 8
      apb(1'b1, `GPF_OFS_OUT, 32'h20);
      apb(1'b1, `GPF_OFS_DIR, 32'h1);
      #1;
      check("oe8", gpio_oe_n[8], 1'b0);
      check("out8", gpio_out[8], 1'b1);
      @(posedge mclk);
      apb(1'b1, `GPF_OFS_DIR, 32'h0);
      // Events on pins 8 to 13: masked, unmasked, cleared, both routes
      for (int p = 0; p < 6; p++) begin
         apb(1'b1, `GPF_OFS_MASK, 32'h0);
         apb(1'b1, `GPF_OFS_INTCFG,
             (32'h101 << p) | (32'(p % 2) << (p + 16)));
         ext_lvl[p + 8] <= 1'b1;
         repeat (8) @(posedge mclk);
         #1;
         check("irq masked", irq, 1'b0);
         @(posedge mclk);
         apb(1'b1, `GPF_OFS_MASK, 32'h1 << p);
         wait_irq();
         #1;
         check("event", system_mgmt_event, p % 2 == 0);
         check("alert_n", bus_alert_n, p % 2 == 0);
         @(posedge mclk);
         rd(`GPF_OFS_STATUS, 32'h1 << p, 1'b0);
         #1;
         check("irq clr", irq, 1'b0);
         @(posedge mclk);
         ext_lvl[p + 8] <= 1'b0;
         rd(`GPF_OFS_STATUS, 32'h0, 1'b0);
      end
      // Secondary bus select codes on pins 12 and 13
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, `GPF_OFS_BUSSEL, 32'h100 | c);
         #1;
         check("bus en", sec_bus_en, c == 0 ? 0 : 3'h1 << (c - 1));
         check("sel pins", gpio_out[13:12], c);
         check("sel oe", gpio_oe_n[13:12], 2'h0);
         @(posedge mclk);
      end
      apb(1'b1, `GPF_OFS_BUSSEL, 32'h0);
      #1;
      check("sel off", gpio_oe_n[13:12], 2'h3);
      @(posedge mclk);
      end_of_test();
   end
endmodule // testbench
`default_nettype wire
